// ==== inc/frac_cfg_pkg.sv ====
// Purpose: Constants and types for the fractional synthesizer output configuration bank.
// Assumes: 16-bit registers addressed by their word index.
// Notes: Field positions and reset values are shared by design and bench.
`default_nettype none
package frac_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    // ------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SEED_LOW = 8'h29;
    localparam logic [7:0] OFS_NUM_HIGH = 8'h2A;
    localparam logic [7:0] OFS_NUM_LOW = 8'h2B;
    localparam logic [7:0] OFS_OUT_CTRL = 8'h2C;
    localparam logic [7:0] OFS_SRC_PWR = 8'h2D;
    localparam logic [7:0] OFS_SRC_B = 8'h2E;
    localparam logic [7:0] OFS_FIXED = 8'h2F;
    // ------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------
    localparam logic [15:0] RST_SEED_LOW = 16'h0000;
    localparam logic [15:0] RST_NUM_HIGH = 16'h0000;
    localparam logic [15:0] RST_NUM_LOW = 16'h0000;
    localparam logic [15:0] RST_OUT_CTRL = 16'h22A2;
    localparam logic [15:0] RST_SRC_PWR = 16'hC622;
    localparam logic [15:0] RST_SRC_B = 16'h07F0;
    localparam logic [15:0] RST_FIXED = 16'h0300;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;
    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int A_PWR_LSB = 8;
    localparam int A_PWR_MSB = 13;
    localparam int B_PD_BIT = 7;
    localparam int A_PD_BIT = 6;
    localparam int MOD_RST_BIT = 5;
    localparam int ORDER_MSB = 2;
    localparam int A_SRC_LSB = 11;
    localparam int A_SRC_MSB = 12;
    localparam int B_PWR_MSB = 5;
    localparam int B_SRC_MSB = 1;
    localparam logic [2:0] ORDER_MAX = 3'h3;
    // Modulator order codes.
    typedef enum logic [2:0] {
        ORDER_INTEGER = 3'h0,
        ORDER_FIRST = 3'h1,
        ORDER_SECOND = 3'h2,
        ORDER_THIRD = 3'h3
    } mod_order_type;
    // Bundle of analog and engine controls leaving the bank.
    typedef struct packed {
        logic [31:0] modulator_seed_low16;
        logic [31:0] frac_numerator;
        logic [5:0] first_out_drive_level;
        logic [5:0] second_out_drive_level;
        logic first_out_powerdown;
        logic second_out_powerdown;
        logic modulator_reset_low;
        logic [2:0] modulator_order;
        logic [1:0] first_out_source;
        logic [1:0] second_out_source;
    } synth_ctrl_type;
endpackage
`default_nettype wire

// ==== verification/synth_frac_output_config_regs_bench.sv ====
// Purpose: Self-checking bench for the output configuration register bank.
// Assumes: Host always writes the prescribed values into reserved fields.
// Notes: Read data are checked only in the cycle after the strobe, though they hold until the next read strobe.
`default_nettype none
module synth_frac_output_config_regs_bench
    import frac_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus signals and the design.
    // ------------------------------------------------------------
    typedef logic [$bits(synth_ctrl_type)-1:0] wide_type;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = 8'h00;
    logic [DATA_W-1:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [DATA_W-1:0] rdata_out;
    synth_ctrl_type ctrl_out;
    synth_ctrl_type exp_c;
    int fails = 0;
    int checks = 0;
    logic [7:0] ofs [7] = '{OFS_SEED_LOW, OFS_NUM_HIGH, OFS_NUM_LOW, OFS_OUT_CTRL, OFS_SRC_PWR, OFS_SRC_B, OFS_FIXED};
    logic [15:0] rst [7] = '{RST_SEED_LOW, RST_NUM_HIGH, RST_NUM_LOW, RST_OUT_CTRL, RST_SRC_PWR, RST_SRC_B, RST_FIXED};

    synth_frac_output_config_regs u_dut (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .ctrl_out(ctrl_out)
    );

    // The 25 MHz clock.
    always #20 clk_in = ~clk_in;

    // ------------------------------------------------------------
    // Access and comparison tasks.
    // ------------------------------------------------------------
    // Compares on four states so that an unknown never passes.
    task automatic check(input string name, input wide_type seen, input wide_type exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe; returns in the low phase after the capturing edge.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(negedge clk_in);
    endtask

    // One-cycle read strobe; data are looked at in the following cycle only.
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        check("rdata_out", wide_type'(rdata_out), wide_type'(exp));
    endtask

    // Waits one more cycle, which also covers the extra lag of the order field.
    task automatic chkc();
        @(negedge clk_in);
        check("ctrl_out", ctrl_out, exp_c);
    endtask

    // Expected controls after any reset, and a sweep of every word.
    task automatic reset_state();
        exp_c = '{32'h0, 32'h0, 6'h22, 6'h22, 1'b0, 1'b1, 1'b1, 3'h2, 2'h0, 2'h0};
        chkc();
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i], rst[i]);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog: the sequence needs well under a thousand cycles.
    // ------------------------------------------------------------
    initial begin
        repeat (3000) @(posedge clk_in);
        fails++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        reset_state();
        wr(OFS_SEED_LOW, 16'hA5C3);
        exp_c.modulator_seed_low16 = 32'h0000A5C3;
        chkc();
        // Back-to-back numerator halves with the strobe held high.
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= OFS_NUM_HIGH;
        wdata_in <= 16'h8001;
        @(posedge clk_in);
        addr_in <= OFS_NUM_LOW;
        wdata_in <= 16'h7FFE;
        // The read follows the last write with no gap and must already see it.
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        check("rdata_out", wide_type'(rdata_out), wide_type'(16'h7FFE));
        exp_c.frac_numerator = 32'h80017FFE;
        chkc();
        wr(OFS_OUT_CTRL, 16'h1F43);
        exp_c.first_out_drive_level = 6'h1F;
        exp_c.first_out_powerdown = 1'b1;
        exp_c.second_out_powerdown = 1'b0;
        exp_c.modulator_reset_low = 1'b0;
        exp_c.modulator_order = 3'h3;
        chkc();
        wr(OFS_SRC_PWR, 16'hC8DF);
        wr(OFS_SRC_B, 16'h07FE);
        exp_c.second_out_drive_level = 6'h1F;
        exp_c.first_out_source = 2'h1;
        exp_c.second_out_source = 2'h2;
        chkc();
        rd(OFS_OUT_CTRL, 16'h1F43);
        rd(OFS_SRC_PWR, 16'hC8DF);
        rd(OFS_SRC_B, 16'h07FE);
        // Order codes 0 to 3 in turn, first source codes 0 and 1, second source codes 0 to 2, with drive levels at zero.
        for (int i = 0; i < 4; i++) begin
            wr(OFS_OUT_CTRL, 16'h0020 | 16'(i));
            wr(OFS_SRC_PWR, 16'hC0C0 | (16'(i % 2) << 11));
            wr(OFS_SRC_B, 16'h07FC | 16'(i % 3));
            exp_c = '{32'h0000A5C3, 32'h80017FFE, 6'h00, 6'h00, 1'b0, 1'b0, 1'b1, 3'(i), 2'(i % 2), 2'(i % 3)};
            chkc();
        end
        // An unused order code is stored but never reaches the modulator.
        wr(OFS_OUT_CTRL, 16'h0025);
        chkc();
        rd(OFS_OUT_CTRL, 16'h0025);
        // Unmapped places neither store nor disturb anything.
        wr(8'h30, 16'hFFFF);
        rd(8'h30, UNMAPPED_READ);
        rd(8'h28, UNMAPPED_READ);
        rd(OFS_NUM_HIGH, 16'h8001);
        rd(OFS_NUM_LOW, 16'h7FFE);
        wr(OFS_FIXED, 16'h0300);
        rd(OFS_FIXED, 16'h0300);
        chkc();
        // A second reset in mid-run brings every word back.
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        reset_state();
        final_report();
    end
endmodule
`default_nettype wire

// ==== verilog/synth_frac_output_config_regs.sv ====
// Purpose: Register bank for seed, numerator, modulator and RF output controls.
// Assumes: Host writes documented values into reserved fields.
// Notes: Read data stands one cycle after the read strobe.
// Operation
// [R1] Seed low half feeds fractional engine start.
// [R2] Numerator upper half at 0x2A, resets zero.
// [R3] Numerator lower half at 0x2B, resets zero.
// [R4] First output drive level in bits 13:8.
// [R5] Second output drive level in bits 5:0.
// [R6] Bit 7 powers down second output, reset one.
// [R7] Bit 6 powers down first output, reset zero.
// [R8] Bit 5 active-low modulator reset, reset one.
// [R9] Bits 2:0 select order; unused codes not applied.
// [R10] Bits 12:11 pick first output source.
// [R11] Bits 1:0 pick second output source.
// [R12] Host writes 6 into bits 15:13.
// [R13] Host writes 3 into bits 10:6.
// [R14] Host writes 0x1FF into bits 15:2.
// [R15] Registers hold values; reads have no effects.
//
// Chosen here: strobed register access.
`default_nettype none
module synth_frac_output_config_regs
    import frac_cfg_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register port.
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    // Controls to the engine and the output stages.
    output synth_ctrl_type ctrl_out
);
    // ------------------------------------------------------------
    // Register storage.
    // ------------------------------------------------------------
    logic [15:0] seed_low_r, seed_low_nxt;
    logic [15:0] num_high_r, num_high_nxt;
    logic [15:0] num_low_r, num_low_nxt;
    logic [15:0] out_ctrl_r, out_ctrl_nxt;
    logic [15:0] src_pwr_r, src_pwr_nxt;
    logic [15:0] src_b_r, src_b_nxt;
    logic [15:0] fixed_r, fixed_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [2:0] order_r, order_nxt;

    // Write decode; a word changes only on a write to its own offset.
    always_comb begin
        seed_low_nxt = seed_low_r;
        num_high_nxt = num_high_r;
        num_low_nxt = num_low_r;
        out_ctrl_nxt = out_ctrl_r;
        src_pwr_nxt = src_pwr_r;
        src_b_nxt = src_b_r;
        fixed_nxt = fixed_r;
        if (wr_in) begin
            case (addr_in)
                OFS_SEED_LOW: seed_low_nxt = wdata_in; // R1
                OFS_NUM_HIGH: num_high_nxt = wdata_in; // R2
                OFS_NUM_LOW: num_low_nxt = wdata_in; // R3
                OFS_OUT_CTRL: out_ctrl_nxt = wdata_in; // R15
                OFS_SRC_PWR: src_pwr_nxt = wdata_in; // R15
                OFS_SRC_B: src_b_nxt = wdata_in; // R15
                OFS_FIXED: fixed_nxt = wdata_in;
                default: fixed_nxt = fixed_r;
            endcase
        end
    end

    // Applied order: unused codes are refused so the engine never sees them.
    // The word keeps the raw code for readback; only this copy filters it, at the cost of one cycle.
    always_comb begin
        order_nxt = order_r;
        if (out_ctrl_r[ORDER_MSB:0] <= ORDER_MAX) begin
            order_nxt = out_ctrl_r[ORDER_MSB:0]; // R9
        end
    end

    // Read mux; reads only sample, nothing else changes.
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_in) begin
            case (addr_in)
                OFS_SEED_LOW: rdata_nxt = seed_low_r;
                OFS_NUM_HIGH: rdata_nxt = num_high_r;
                OFS_NUM_LOW: rdata_nxt = num_low_r;
                OFS_OUT_CTRL: rdata_nxt = out_ctrl_r;
                OFS_SRC_PWR: rdata_nxt = src_pwr_r;
                OFS_SRC_B: rdata_nxt = src_b_r;
                OFS_FIXED: rdata_nxt = fixed_r;
                default: rdata_nxt = UNMAPPED_READ;
            endcase
        end
    end

    // Configuration words; this process only registers what the write decode chose.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seed_low_r <= RST_SEED_LOW;
            num_high_r <= RST_NUM_HIGH;
            num_low_r <= RST_NUM_LOW;
            out_ctrl_r <= RST_OUT_CTRL;
            src_pwr_r <= RST_SRC_PWR;
            src_b_r <= RST_SRC_B;
            fixed_r <= RST_FIXED;
        end else begin
            seed_low_r <= seed_low_nxt;
            num_high_r <= num_high_nxt;
            num_low_r <= num_low_nxt;
            out_ctrl_r <= out_ctrl_nxt;
            src_pwr_r <= src_pwr_nxt;
            src_b_r <= src_b_nxt;
            fixed_r <= fixed_nxt;
        end
    end

    // Applied order; it resets to the second-order code so that it matches the reset word.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            order_r <= ORDER_SECOND;
        end else begin
            order_r <= order_nxt;
        end
    end

    // Read data; they hold until the next read strobe replaces them.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_r <= UNMAPPED_READ;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Field outputs.
    // ------------------------------------------------------------
    // The upper seed half lives elsewhere, so its slots read zero here.
    always_comb begin
        ctrl_out.modulator_seed_low16 = {16'h0000, seed_low_r}; // R1
        ctrl_out.frac_numerator = {num_high_r, num_low_r}; // R2
        ctrl_out.first_out_drive_level = out_ctrl_r[A_PWR_MSB:A_PWR_LSB]; // R4
        ctrl_out.second_out_drive_level = src_pwr_r[B_PWR_MSB:0]; // R5
        ctrl_out.second_out_powerdown = out_ctrl_r[B_PD_BIT]; // R6
        ctrl_out.first_out_powerdown = out_ctrl_r[A_PD_BIT]; // R7
        ctrl_out.modulator_reset_low = out_ctrl_r[MOD_RST_BIT]; // R8
        ctrl_out.modulator_order = order_r; // R9
        ctrl_out.first_out_source = src_pwr_r[A_SRC_MSB:A_SRC_LSB]; // R10
        ctrl_out.second_out_source = src_b_r[B_SRC_MSB:0]; // R11
    end

    // Read data leave straight from their register.
    assign rdata_out = rdata_r; // R15

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    // Each write lands in its own field at the next edge.
    property p_seed_write;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_SEED_LOW) |=> ctrl_out.modulator_seed_low16[15:0] == $past(wdata_in);
    endproperty
    a_seed_write: assert property (p_seed_write) else $error("seed write lost"); // R1
    property p_num_high;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_NUM_HIGH) |=> ctrl_out.frac_numerator[31:16] == $past(wdata_in);
    endproperty
    a_num_high: assert property (p_num_high) else $error("numerator high wrong"); // R2
    property p_num_low;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_NUM_LOW) |=> ctrl_out.frac_numerator[15:0] == $past(wdata_in);
    endproperty
    a_num_low: assert property (p_num_low) else $error("numerator low wrong"); // R3
    property p_a_pwr;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_OUT_CTRL) |=> ctrl_out.first_out_drive_level == $past(wdata_in[13:8]);
    endproperty
    a_a_pwr: assert property (p_a_pwr) else $error("first drive level wrong"); // R4
    property p_b_pwr;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_SRC_PWR) |=> ctrl_out.second_out_drive_level == $past(wdata_in[5:0]);
    endproperty
    a_b_pwr: assert property (p_b_pwr) else $error("second drive level wrong"); // R5
    property p_pd_bits;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_OUT_CTRL) |=> ctrl_out.second_out_powerdown == $past(wdata_in[7])
            && ctrl_out.first_out_powerdown == $past(wdata_in[6]) && ctrl_out.modulator_reset_low == $past(wdata_in[5]);
    endproperty
    a_pd_bits: assert property (p_pd_bits) else $error("powerdown or modulator reset wrong"); // R6
    property p_first_pd;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_OUT_CTRL) |=> ctrl_out.first_out_powerdown == $past(wdata_in[6]);
    endproperty
    a_first_pd: assert property (p_first_pd) else $error("first output powerdown wrong"); // R7
    property p_mod_reset;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_OUT_CTRL) |=> ctrl_out.modulator_reset_low == $past(wdata_in[5]);
    endproperty
    a_mod_reset: assert property (p_mod_reset) else $error("modulator reset bit wrong"); // R8

    // Order filter: legal codes arrive one edge after the word, unused codes never arrive.
    property p_order_legal;
        @(posedge clk_in) disable iff (!arst_n_in)
        ctrl_out.modulator_order <= ORDER_MAX;
    endproperty
    a_order_legal: assert property (p_order_legal) else $error("unused order applied"); // R9
    property p_order_follow;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_OUT_CTRL && wdata_in[2:0] <= ORDER_MAX)
            |=> ##1 ctrl_out.modulator_order == $past(wdata_in[2:0], 2);
    endproperty
    a_order_follow: assert property (p_order_follow) else $error("order not applied"); // R9
    property p_order_keep;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_OUT_CTRL && wdata_in[2:0] > ORDER_MAX)
            |=> ##1 $stable(ctrl_out.modulator_order);
    endproperty
    a_order_keep: assert property (p_order_keep) else $error("unused order code reached the modulator"); // R9
    property p_order_still;
        @(posedge clk_in) disable iff (!arst_n_in)
        !(wr_in && addr_in == OFS_OUT_CTRL) ##1 !(wr_in && addr_in == OFS_OUT_CTRL)
            |=> $stable(ctrl_out.modulator_order);
    endproperty
    a_order_still: assert property (p_order_still) else $error("order moved without a write"); // R9

    // Source selections.
    property p_sources;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_SRC_B) |=> ctrl_out.second_out_source == $past(wdata_in[1:0]);
    endproperty
    a_sources: assert property (p_sources) else $error("second source wrong"); // R11
    property p_src_a;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && addr_in == OFS_SRC_PWR) |=> ctrl_out.first_out_source == $past(wdata_in[12:11]);
    endproperty
    a_src_a: assert property (p_src_a) else $error("first source wrong"); // R10

    // Read path: a read returns the stored word and touches nothing else.
    property p_readback;
        @(posedge clk_in) disable iff (!arst_n_in)
        (rd_in && addr_in == OFS_NUM_LOW && !wr_in) |=> rdata_out == ctrl_out.frac_numerator[15:0];
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // R15
    property p_num_high_read;
        @(posedge clk_in) disable iff (!arst_n_in)
        (rd_in && addr_in == OFS_NUM_HIGH && !wr_in) |=> rdata_out == ctrl_out.frac_numerator[31:16];
    endproperty
    a_num_high_read: assert property (p_num_high_read) else $error("numerator high readback mismatch"); // R15
    property p_seed_read;
        @(posedge clk_in) disable iff (!arst_n_in)
        (rd_in && addr_in == OFS_SEED_LOW && !wr_in) |=> rdata_out == ctrl_out.modulator_seed_low16[15:0];
    endproperty
    a_seed_read: assert property (p_seed_read) else $error("seed readback mismatch"); // R15
    property p_ctrl_read;
        @(posedge clk_in) disable iff (!arst_n_in)
        (rd_in && addr_in == OFS_OUT_CTRL && !wr_in) |=> rdata_out[13:8] == ctrl_out.first_out_drive_level;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("output control readback mismatch"); // R15
    property p_srcb_read;
        @(posedge clk_in) disable iff (!arst_n_in)
        (rd_in && addr_in == OFS_SRC_B && !wr_in) |=> rdata_out[1:0] == ctrl_out.second_out_source;
    endproperty
    a_srcb_read: assert property (p_srcb_read) else $error("second source readback mismatch"); // R15
    property p_unmapped_read;
        @(posedge clk_in) disable iff (!arst_n_in)
        (rd_in && (addr_in < OFS_SEED_LOW || addr_in > OFS_FIXED)) |=> rdata_out == UNMAPPED_READ;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // R15
    property p_read_hold;
        @(posedge clk_in) disable iff (!arst_n_in)
        !rd_in |=> $stable(rdata_out);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data changed without a read"); // R15

    // Holding: no field moves without a write to its own word.
    property p_hold;
        @(posedge clk_in) disable iff (!arst_n_in)
        !wr_in |=> $stable(ctrl_out.frac_numerator) && $stable(ctrl_out.first_out_drive_level);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write"); // R15
    property p_hold_rest;
        @(posedge clk_in) disable iff (!arst_n_in)
        !wr_in |=> $stable(ctrl_out.modulator_seed_low16) && $stable(ctrl_out.second_out_drive_level)
            && $stable(ctrl_out.first_out_source) && $stable(ctrl_out.second_out_source);
    endproperty
    a_hold_rest: assert property (p_hold_rest) else $error("seed, level or source changed without write"); // R15
    property p_hold_pd;
        @(posedge clk_in) disable iff (!arst_n_in)
        !wr_in |=> $stable(ctrl_out.first_out_powerdown) && $stable(ctrl_out.second_out_powerdown)
            && $stable(ctrl_out.modulator_reset_low);
    endproperty
    a_hold_pd: assert property (p_hold_pd) else $error("powerdown bit changed without write"); // R15
    property p_unmapped_write;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_in && (addr_in < OFS_SEED_LOW || addr_in > OFS_FIXED)) |=> $stable(ctrl_out.frac_numerator)
            && $stable(ctrl_out.modulator_seed_low16) && $stable(ctrl_out.first_out_drive_level)
            && $stable(ctrl_out.second_out_drive_level) && $stable(ctrl_out.second_out_source);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write disturbed a field"); // R15

    // Coverage of the main scenarios.
    c_num_write: cover property (@(posedge clk_in) disable iff (!arst_n_in) wr_in && addr_in == OFS_NUM_HIGH);
    c_bad_order: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        wr_in && addr_in == OFS_OUT_CTRL && wdata_in[2:0] > ORDER_MAX);
    c_read_back: cover property (@(posedge clk_in) disable iff (!arst_n_in) wr_in ##1 rd_in);
    c_back_to_back: cover property (@(posedge clk_in) disable iff (!arst_n_in) wr_in ##1 wr_in);
    c_unmapped_read: cover property (@(posedge clk_in) disable iff (!arst_n_in) rd_in && addr_in > OFS_FIXED);
endmodule
`default_nettype wire
